/* design/eoc_consts.svh */
`ifndef EOC_CONSTS_SVH
`define EOC_CONSTS_SVH

// ==================================================
// register map
`define EOC_ADDR_W          8
`define EOC_DATA_W          8
`define EOC_ADDR_CTRL       8'hB1
`define EOC_ADDR_IRQ_STAT   8'hB2
`define EOC_ADDR_IRQ_MASK   8'hB3
`define EOC_ADDR_MON        8'hB4

// ==================================================
// reset values
`define EOC_CTRL_RESET      8'h00
`define EOC_IRQ_RESET       2'h0

// ==================================================
// field positions
`define EOC_CTRL_VALID_BIT  7
`define EOC_CTRL_MODE_HI    6
`define EOC_CTRL_MODE_LO    4
`define EOC_CTRL_UNUSED_BIT 3
`define EOC_CTRL_FREQ_HI    2
`define EOC_CTRL_FREQ_LO    0
`define EOC_IRQ_W           2
`define EOC_IRQ_VALID_UP    0
`define EOC_IRQ_VALID_DOWN  1
`define EOC_MON_RUN_BIT     7
`define EOC_MON_QUAL_BIT    6
`define EOC_MON_LEVEL_BIT   5
`define EOC_MON_DIV_BIT     4

// ==================================================
// timing
`define EOC_CLK_PERIOD_NS   8
`define EOC_GAP_TIME_NS     100000
`define EOC_QUAL_EDGES      1024

`endif

/* design/eoc_pkg.sv */
package eoc_pkg;

   // ==================================================
   // oscillator mode field encoding
   typedef enum logic [2:0] {
      EOC_MODE_OFF0      = 3'b000,
      EOC_MODE_OFF1      = 3'b001,
      EOC_MODE_CMOS      = 3'b010,
      EOC_MODE_CMOS_DIV2 = 3'b011,
      EOC_MODE_RC_DIV2   = 3'b100,
      EOC_MODE_CAP_DIV2  = 3'b101,
      EOC_MODE_XTAL      = 3'b110,
      EOC_MODE_XTAL_DIV2 = 3'b111
   } eoc_mode_t;

   // ==================================================
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } eoc_bus_req_t;

   // ==================================================
   // derived clock towards the clock switch
   typedef struct packed {
      logic tick;
      logic level;
   } eoc_clk_out_t;

   // ==================================================
   // drive circuit configuration towards the analog cell
   typedef struct packed {
      logic       drive_en;
      logic       xtal_pins;
      logic       cmos_in;
      eoc_mode_t  mode;
      logic [2:0] freq_range;
   } eoc_drive_cfg_t;

endpackage

/* design/eoc_osc_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "eoc_consts.svh"

module eoc_osc_monitor #(
   parameter int GAP_CYCLES = `EOC_GAP_TIME_NS / `EOC_CLK_PERIOD_NS,
   parameter int QUAL_EDGES = `EOC_QUAL_EDGES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic osc_pin_in,
   input  wire logic enable,
   input  wire logic restart,
   output logic      edge_pulse,
   output logic      level,
   output logic      running,
   output logic      qualified
);
   import eoc_pkg::*;

   localparam int GW = $clog2(GAP_CYCLES + 1);
   localparam int EW = $clog2(QUAL_EDGES + 1);
   localparam logic [GW-1:0] GAP_LAST  = GW'(GAP_CYCLES - 1);
   localparam logic [EW-1:0] EDGE_LAST = EW'(QUAL_EDGES - 1);

   typedef struct packed {
      logic          meta;
      logic          sync;
      logic          prev;
      logic [GW-1:0] gap;
      logic [EW-1:0] edges;
      logic          running;
      logic          qualified;
   } eoc_mon_state_t;

   eoc_mon_state_t s_q;
   eoc_mon_state_t s_d;
   logic           rise;

   // ==================================================
   // edge qualification
   always_comb begin
      s_d      = s_q;
      s_d.meta = osc_pin_in;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
      rise     = s_q.sync & ~s_q.prev;
      if (!enable || restart) begin
         s_d.gap       = '0;
         s_d.edges     = '0;
         s_d.running   = 1'b0;
         s_d.qualified = 1'b0;
      end else if (rise) begin
         s_d.gap     = '0;
         s_d.running = 1'b1;
         if (s_q.edges != EDGE_LAST) begin
            s_d.edges = s_q.edges + EW'(1);
         end else begin
            s_d.qualified = 1'b1;
         end
      end else if (s_q.gap == GAP_LAST) begin
         // a stall longer than the slowest range means the oscillator died
         s_d.gap       = '0;
         s_d.edges     = '0;
         s_d.running   = 1'b0;
         s_d.qualified = 1'b0;
      end else begin
         s_d.gap = s_q.gap + GW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign edge_pulse = rise;
   assign level      = s_q.sync;
   assign running    = s_q.running;
   assign qualified  = s_q.qualified;

endmodule

`default_nettype wire

/* design/eoc_top.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "eoc_consts.svh"

module eoc_top #(
   parameter int GAP_CYCLES = `EOC_GAP_TIME_NS / `EOC_CLK_PERIOD_NS,
   parameter int QUAL_EDGES = `EOC_QUAL_EDGES
) (
   input  wire logic                  CLK,
   input  wire logic                  SYS_RST,
   input  wire eoc_pkg::eoc_bus_req_t BUS_REQ,
   output logic [7:0]                 BUS_RDATA,
   input  wire logic                  OSC_PIN_IN,
   output eoc_pkg::eoc_drive_cfg_t    OSC_CFG,
   output eoc_pkg::eoc_clk_out_t      EXT_CLK,
   output logic                       EXT_CLOCK_VALID,
   output logic                       IRQ
);
   import eoc_pkg::*;

   // ==================================================
   // state
   typedef struct packed {
      eoc_mode_t                mode;
      logic [2:0]               freq;
      logic [`EOC_IRQ_W-1:0]    stat;
      logic [`EOC_IRQ_W-1:0]    mask;
      logic                     valid;
      logic                     div;
      logic                     tick;
      logic                     level;
      logic [`EOC_DATA_W-1:0]   rdata;
   } eoc_state_t;

   eoc_state_t s_q;
   eoc_state_t s_d;

   logic       mon_edge;
   logic       mon_level;
   logic       mon_running;
   logic       mon_qualified;
   logic       mon_restart;

   // ==================================================
   // mode decoding
   function automatic logic mode_on(input eoc_mode_t m);
      mode_on = (m != EOC_MODE_OFF0) && (m != EOC_MODE_OFF1);
   endfunction

   function automatic logic mode_cmos(input eoc_mode_t m);
      mode_cmos = (m == EOC_MODE_CMOS) || (m == EOC_MODE_CMOS_DIV2);
   endfunction

   function automatic logic mode_div2(input eoc_mode_t m);
      case (m)
         EOC_MODE_CMOS_DIV2: mode_div2 = 1'b1;
         EOC_MODE_RC_DIV2:   mode_div2 = 1'b1;
         EOC_MODE_CAP_DIV2:  mode_div2 = 1'b1;
         EOC_MODE_XTAL_DIV2: mode_div2 = 1'b1;
         default:            mode_div2 = 1'b0;
      endcase
   endfunction

   function automatic logic mode_xtal(input eoc_mode_t m);
      mode_xtal = (m == EOC_MODE_XTAL) || (m == EOC_MODE_XTAL_DIV2);
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
      is_addr = (a == ref_a);
   endfunction

   // ==================================================
   // register read-back image
   function automatic logic [7:0] ctrl_image(input eoc_state_t s);
      logic [7:0] v;
      v                                       = '0;
      v[`EOC_CTRL_VALID_BIT]                  = s.valid;
      v[`EOC_CTRL_MODE_HI:`EOC_CTRL_MODE_LO]  = s.mode;
      v[`EOC_CTRL_UNUSED_BIT]                 = 1'b0;
      v[`EOC_CTRL_FREQ_HI:`EOC_CTRL_FREQ_LO]  = s.freq;
      ctrl_image                              = v;
   endfunction

   // ==================================================
   // activity monitor
   eoc_osc_monitor #(
      .GAP_CYCLES (GAP_CYCLES),
      .QUAL_EDGES (QUAL_EDGES)
   ) u_monitor (
      .clk        (CLK),
      .rst        (SYS_RST),
      .osc_pin_in (OSC_PIN_IN),
      .enable     (mode_on(s_q.mode)),
      .restart    (mon_restart),
      .edge_pulse (mon_edge),
      .level      (mon_level),
      .running    (mon_running),
      .qualified  (mon_qualified)
   );

   // ==================================================
   // next state
   logic                  wr_ctrl;
   logic                  wr_stat;
   logic                  wr_mask;
   logic                  valid_now;
   logic [`EOC_IRQ_W-1:0] set_ev;
   logic [`EOC_IRQ_W-1:0] clr_ev;
   eoc_mode_t             new_mode;

   always_comb begin
      s_d       = s_q;
      wr_ctrl   = BUS_REQ.wr && is_addr(BUS_REQ.addr, `EOC_ADDR_CTRL);
      wr_stat   = BUS_REQ.wr && is_addr(BUS_REQ.addr, `EOC_ADDR_IRQ_STAT);
      wr_mask   = BUS_REQ.wr && is_addr(BUS_REQ.addr, `EOC_ADDR_IRQ_MASK);
      new_mode  = eoc_mode_t'(BUS_REQ.wdata[`EOC_CTRL_MODE_HI:`EOC_CTRL_MODE_LO]);
      // any mode change restarts qualification; the new oscillator must prove itself
      mon_restart = wr_ctrl && (new_mode != s_q.mode);
      set_ev    = '0;
      clr_ev    = '0;

      // control register; bit 3 is simply not stored
      if (wr_ctrl) begin
         s_d.mode = new_mode;
         s_d.freq = BUS_REQ.wdata[`EOC_CTRL_FREQ_HI:`EOC_CTRL_FREQ_LO];
      end
      if (wr_mask) begin
         s_d.mask = BUS_REQ.wdata[`EOC_IRQ_W-1:0];
      end

      // valid flag: forced low in CMOS input modes and while off
      valid_now = mon_qualified && mode_on(s_q.mode) && !mode_cmos(s_q.mode)
                  && !mon_restart;
      s_d.valid = valid_now;
      set_ev[`EOC_IRQ_VALID_UP]   = valid_now && !s_q.valid;
      set_ev[`EOC_IRQ_VALID_DOWN] = !valid_now && s_q.valid;
      if (wr_stat) begin
         clr_ev = BUS_REQ.wdata[`EOC_IRQ_W-1:0];
      end
      // a new event outranks a simultaneous write-one-to-clear
      s_d.stat = (s_q.stat & ~clr_ev) | set_ev;

      // derived clock
      s_d.tick = 1'b0;
      if (!mode_on(s_q.mode) || mon_restart) begin
         s_d.div   = 1'b0;
         s_d.level = 1'b0;
      end else if (mode_div2(s_q.mode)) begin
         // toggling once per oscillator period halves its frequency with an even duty cycle
         if (mon_edge) begin
            s_d.div   = ~s_q.div;
            s_d.level = ~s_q.level;
            s_d.tick  = s_q.div;
         end
      end else begin
         s_d.div   = 1'b0;
         s_d.level = mon_level;
         s_d.tick  = mon_edge;
      end

      // read data, valid only in the cycle after the strobe
      s_d.rdata = '0;
      if (BUS_REQ.rd) begin
         case (BUS_REQ.addr)
            `EOC_ADDR_CTRL:     s_d.rdata = ctrl_image(s_q);
            `EOC_ADDR_IRQ_STAT: s_d.rdata = {{(8-`EOC_IRQ_W){1'b0}}, s_q.stat};
            `EOC_ADDR_IRQ_MASK: s_d.rdata = {{(8-`EOC_IRQ_W){1'b0}}, s_q.mask};
            `EOC_ADDR_MON: begin
               s_d.rdata[`EOC_MON_RUN_BIT]   = mon_running;
               s_d.rdata[`EOC_MON_QUAL_BIT]  = mon_qualified;
               s_d.rdata[`EOC_MON_LEVEL_BIT] = mon_level;
               s_d.rdata[`EOC_MON_DIV_BIT]   = s_q.div;
            end
            default:            s_d.rdata = '0;
         endcase
      end
   end

   // ==================================================
   // registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         s_q       <= '0;
         s_q.mode  <= eoc_mode_t'(`EOC_CTRL_RESET >> `EOC_CTRL_MODE_LO);
         s_q.freq  <= 3'(`EOC_CTRL_RESET);
         s_q.stat  <= `EOC_IRQ_RESET;
         s_q.mask  <= `EOC_IRQ_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ==================================================
   // outputs
   assign BUS_RDATA          = s_q.rdata;
   assign EXT_CLK.tick       = s_q.tick;
   assign EXT_CLK.level      = s_q.level;
   assign EXT_CLOCK_VALID    = s_q.valid;
   assign IRQ                = |(s_q.stat & s_q.mask);
   assign OSC_CFG.drive_en   = mode_on(s_q.mode);
   assign OSC_CFG.xtal_pins  = mode_xtal(s_q.mode);
   assign OSC_CFG.cmos_in    = mode_cmos(s_q.mode);
   assign OSC_CFG.mode       = s_q.mode;
   assign OSC_CFG.freq_range = s_q.freq;

endmodule

`default_nettype wire

/* bench/eoc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "eoc_consts.svh"

module eoc_checker #(
   parameter int QUAL_EDGES = 4
) (
   input wire logic                    CLK,
   input wire logic                    SYS_RST,
   input wire eoc_pkg::eoc_bus_req_t   BUS_REQ,
   input wire logic [7:0]              BUS_RDATA,
   input wire logic                    OSC_PIN_IN,
   input wire eoc_pkg::eoc_drive_cfg_t OSC_CFG,
   input wire eoc_pkg::eoc_clk_out_t   EXT_CLK,
   input wire logic                    EXT_CLOCK_VALID,
   input wire logic                    IRQ
);
   import eoc_pkg::*;
   // fastest legal pin period is 4 cycles
   localparam int MIN_QUAL = (QUAL_EDGES - 1) * 4;
   eoc_mode_t   mode_q;
   logic [11:0] since_q;
   logic        div2;
   logic        quiet;

   // ==================================================
   // cycles since the last mode change, which restarts the path
   always_ff @(posedge CLK) begin
      mode_q <= OSC_CFG.mode;
      if (SYS_RST || OSC_CFG.mode != mode_q) begin
         since_q <= 12'h000;
      end else if (since_q != 12'hFFF) begin
         since_q <= since_q + 12'h001;
      end
   end
   assign div2  = OSC_CFG.mode[2] ? (OSC_CFG.mode != EOC_MODE_XTAL) : (OSC_CFG.mode == EOC_MODE_CMOS_DIV2);
   assign quiet = !OSC_CFG.mode[2];

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   // ==================================================
   // assertions
   rdata_idle_a: assert property (!$past(BUS_REQ.rd) |-> BUS_RDATA == 8'h00)
      else $error("read data outside its cycle");
   unused_bit_a: assert property (BUS_RDATA[3] == 1'b0)
      else $error("unused bit reads one");
   mode_write_a: assert property ($past(BUS_REQ.wr && BUS_REQ.addr == `EOC_ADDR_CTRL) |->
      OSC_CFG.mode == $past(BUS_REQ.wdata[6:4]) && OSC_CFG.freq_range == $past(BUS_REQ.wdata[2:0]))
      else $error("control write not applied");
   ctrl_read_a: assert property ($past(BUS_REQ.rd && BUS_REQ.addr == `EOC_ADDR_CTRL) |->
      BUS_RDATA[6:0] == {OSC_CFG.mode, 1'b0, OSC_CFG.freq_range})
      else $error("control readback wrong");
   quiet_valid_a: assert property (quiet && $past(quiet) && $past(quiet, 2) |-> !EXT_CLOCK_VALID)
      else $error("valid while off or cmos");
   off_drive_a: assert property (OSC_CFG.mode[2:1] == 2'b00 |-> !OSC_CFG.drive_en)
      else $error("drive on in off mode");
   cfg_decode_a: assert property (OSC_CFG.drive_en == (OSC_CFG.mode[2:1] != 2'b00) &&
      OSC_CFG.cmos_in == (OSC_CFG.mode[2:1] == 2'b01) && OSC_CFG.xtal_pins == (OSC_CFG.mode[2:1] == 2'b11))
      else $error("pin configuration decode wrong");
   valid_qual_a: assert property ($rose(EXT_CLOCK_VALID) |-> since_q >= MIN_QUAL && !quiet)
      else $error("valid before qualification");
   div_level_a: assert property (div2 && since_q > 12'h008 && $rose(EXT_CLK.level) |->
      ##1 (EXT_CLK.level || since_q < 12'h003 || OSC_CFG.mode != mode_q)[*3])
      else $error("divided clock high too short");
   sync_level_a: assert property (OSC_CFG.mode == EOC_MODE_XTAL && since_q > 12'h008 && $rose(OSC_PIN_IN) |->
      ##[2:5] ($rose(EXT_CLK.level) || OSC_CFG.mode != EOC_MODE_XTAL))
      else $error("pin edge not followed");

   valid_up_c: cover property ($rose(EXT_CLOCK_VALID));
   irq_up_c: cover property ($rose(IRQ));
   div_run_c: cover property (div2 && $rose(EXT_CLK.level));
endmodule

`default_nettype wire

/* bench/eoc_osc_model.sv */
`timescale 1ns/1ns
`default_nettype none

module eoc_osc_model #(
   parameter int HALF_NS = 20
) (
   input  wire logic run,
   input  wire logic slow,
   output logic      pin
);
   // ==================================================
   // a stopped crystal rests low; slow doubles the period
   // toggles sit 1 ns off the clock grid so a pin edge never shares a time step with CLK
   initial begin
      pin = 1'b0;
      #1;
      forever begin
         #(slow ? 2 * HALF_NS : HALF_NS);
         pin = run ? ~pin : 1'b0;
      end
   end
endmodule

`default_nettype wire

/* bench/external_oscillator_control_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "eoc_consts.svh"

module external_oscillator_control_test;
   import eoc_pkg::*;
   logic           CLK = 1'b0;
   logic           SYS_RST = 1'b1;
   eoc_bus_req_t   BUS_REQ = '0;
   logic [7:0]     BUS_RDATA;
   logic           OSC_PIN_IN;
   eoc_drive_cfg_t OSC_CFG;
   eoc_clk_out_t   EXT_CLK;
   logic           EXT_CLOCK_VALID;
   logic           IRQ;
   logic           osc_run = 1'b0;
   logic           osc_slow = 1'b0;
   int             n_errors = 0;
   int             tests_run = 0;
   int             ticks;
   logic [7:0]     rd;
   // bits 7 and 3 written high must not stick
   logic [7:0]     row_wr [8] = '{8'h8F, 8'h9E, 8'hAD, 8'hBC, 8'hCB, 8'hDA, 8'hE9, 8'hF8};
   logic [7:0]     row_exp [8] = '{8'h07, 8'h16, 8'h25, 8'h34, 8'h43, 8'h52, 8'h61, 8'h70};

   always #4 CLK = ~CLK;

   eoc_top #(.GAP_CYCLES(20), .QUAL_EDGES(4)) dut (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_REQ(BUS_REQ),
      .BUS_RDATA(BUS_RDATA), .OSC_PIN_IN(OSC_PIN_IN), .OSC_CFG(OSC_CFG), .EXT_CLK(EXT_CLK),
      .EXT_CLOCK_VALID(EXT_CLOCK_VALID), .IRQ(IRQ));
   eoc_osc_model xtal (.run(osc_run), .slow(osc_slow), .pin(OSC_PIN_IN));

   // ==================================================
   // tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge CLK);
      BUS_REQ <= '0;
      // let the registers settle before any caller looks at an output
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      BUS_REQ <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge CLK);
      BUS_REQ <= '0;
      #1 d = BUS_RDATA;
   endtask
   // software polls before it would switch the system clock
   task automatic poll_valid(input logic exp);
      rd = {~exp, 7'h00};
      for (int k = 0; k < 300 && rd[7] !== exp; k++) rd_reg(`EOC_ADDR_CTRL, rd);
      chk({7'h00, rd[7]}, {7'h00, exp});
   endtask
   task automatic count_ticks(input int cycles, input int exp);
      ticks = 0;
      repeat (cycles) begin
         @(posedge CLK);
         #1 ticks += EXT_CLK.tick;
      end
      chk({7'h00, 1'(ticks >= exp - 1 && ticks <= exp + 1)}, 8'h01);
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_errors++;
      test_done;
   end

   // ==================================================
   // main sequence; pin period 5 cycles, 400 cycles give 80 pin edges
   initial begin
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd_reg(`EOC_ADDR_CTRL, rd);
      chk(rd, `EOC_CTRL_RESET);
      rd_reg(`EOC_ADDR_IRQ_MASK, rd);
      chk(rd, 8'h00);
      chk({7'h00, OSC_CFG.drive_en}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr_reg(`EOC_ADDR_CTRL, row_wr[i]);
         rd_reg(`EOC_ADDR_CTRL, rd);
         chk(rd, row_exp[i]);
      end
      wr_reg(8'h00, 8'hFF);
      rd_reg(8'h00, rd);
      chk(rd, 8'h00);
      rd_reg(`EOC_ADDR_CTRL, rd);
      chk(rd, 8'h70);
      // crystal start: pins freed, enable, poll, only then switch
      wr_reg(`EOC_ADDR_IRQ_MASK, 8'h01);
      osc_run <= 1'b1;
      wr_reg(`EOC_ADDR_CTRL, 8'h67);
      poll_valid(1'b1);
      rd_reg(`EOC_ADDR_MON, rd);
      chk(rd & 8'hC0, 8'hC0);
      chk({7'h00, IRQ}, 8'h01);
      rd_reg(`EOC_ADDR_IRQ_STAT, rd);
      chk(rd, 8'h01);
      wr_reg(`EOC_ADDR_IRQ_STAT, 8'h01);
      chk({7'h00, IRQ}, 8'h00);
      count_ticks(400, 80);
      wr_reg(`EOC_ADDR_CTRL, 8'h77);
      count_ticks(400, 40);
      poll_valid(1'b1);
      osc_slow <= 1'b1;
      count_ticks(400, 20);
      wr_reg(`EOC_ADDR_IRQ_STAT, 8'h03);
      osc_run <= 1'b0;
      poll_valid(1'b0);
      rd_reg(`EOC_ADDR_IRQ_STAT, rd);
      chk(rd, 8'h02);
      chk({7'h00, IRQ}, 8'h00);
      wr_reg(`EOC_ADDR_IRQ_MASK, 8'h03);
      chk({7'h00, IRQ}, 8'h01);
      wr_reg(`EOC_ADDR_IRQ_STAT, 8'h02);
      chk({7'h00, IRQ}, 8'h00);
      // cmos modes tick but never report valid
      osc_slow <= 1'b0;
      osc_run <= 1'b1;
      wr_reg(`EOC_ADDR_CTRL, 8'h25);
      count_ticks(400, 80);
      rd_reg(`EOC_ADDR_CTRL, rd);
      chk(rd, 8'h25);
      wr_reg(`EOC_ADDR_CTRL, 8'h35);
      count_ticks(400, 40);
      rd_reg(`EOC_ADDR_CTRL, rd);
      chk(rd, 8'h35);
      wr_reg(`EOC_ADDR_CTRL, 8'h15);
      count_ticks(100, 0);
      rd_reg(`EOC_ADDR_CTRL, rd);
      chk(rd, 8'h15);
      // reset in mid-run drops everything
      wr_reg(`EOC_ADDR_CTRL, 8'h67);
      poll_valid(1'b1);
      @(posedge CLK);
      SYS_RST <= 1'b1;
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd_reg(`EOC_ADDR_CTRL, rd);
      chk(rd, `EOC_CTRL_RESET);
      test_done;
   end
endmodule

bind eoc_top eoc_checker #(.QUAL_EDGES(QUAL_EDGES)) chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_REQ(BUS_REQ),
   .BUS_RDATA(BUS_RDATA), .OSC_PIN_IN(OSC_PIN_IN), .OSC_CFG(OSC_CFG), .EXT_CLK(EXT_CLK),
   .EXT_CLOCK_VALID(EXT_CLOCK_VALID), .IRQ(IRQ));

`default_nettype wire
